/* File: verilog/srh_pkg.sv */
// package for the async sram host controller: timing constants and states
// assumes a 10 MHz core clock; all sram timings fold into whole cycles
package srh_pkg;
  localparam int CLK_PERIOD_NS      = 100;
  // grade figures as printed (slowest grade used as the default)
  localparam int ADDR_SETUP_NS      = 20;  // address valid before write end
  localparam int DATA_SETUP_NS      = 12;  // data valid before write end
  localparam int WRITE_PULSE_NS     = 15;  // strobe low width
  localparam int READ_ACCESS_NS     = 25;  // address/select access time
  localparam int OE_ACCESS_NS       = 9;   // output enable access time
  localparam int FLOAT_NS           = 12;  // select high to data high-z
  localparam int CYCLE_TIME_NS      = 25;  // read or write cycle time
  localparam int SYNC_CYC           = 2;   // flops between the data pins and the read path
  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int WRITE_LOW_CYC      = ns_to_cyc(WRITE_PULSE_NS > DATA_SETUP_NS ?
                                        WRITE_PULSE_NS : DATA_SETUP_NS);
  localparam int READ_WAIT_CYC      = ns_to_cyc(READ_ACCESS_NS > OE_ACCESS_NS ?
                                        READ_ACCESS_NS : OE_ACCESS_NS);
  localparam int FLOAT_CYC          = ns_to_cyc(FLOAT_NS > CYCLE_TIME_NS ?
                                        FLOAT_NS : CYCLE_TIME_NS);
  localparam int ADDR_W             = 13;
  localparam int DATA_W             = 8;
  localparam int CNT_W              = 4;
  typedef enum logic [2:0] {
    SRH_IDLE, SRH_W_SETUP, SRH_W_LOW, SRH_W_END, SRH_R_WAIT, SRH_R_DONE, SRH_RECOVER
  } srh_state_t;
endpackage

/* File: verilog/srh_sync.sv */
// two flip-flop synchroniser for the data pins read back from the sram
// assumes the pins settle long before they are sampled by the read path
`timescale 1ns/1ps
module srh_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  if (WIDTH < 1) begin : g_bad_width
    $error("srh_sync: width must be at least one");
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule // srh_sync

/* File: verilog/srh_ctrl.sv */
// host controller driving an 8k x 8 asynchronous sram through its pins
// assumes one user request at a time; sram pins are wired straight to the device
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - write happens only while both selects active and write strobe low.
// - host raises all three write qualifiers before the write can begin.
// - host ends write by dropping one qualifier; first drop ends it.
// - write data valid at least setup time before the ending edge.
// - write data held stable through the ending edge.
// - address stable at least setup time before write ends.
// - address set before write starts, may change after it ends.
// - host holds write strobe high through every read cycle.
// - host has address valid before both selects go active on read; the code sets address and selects on the same edge.
module srh_ctrl
  import srh_pkg::*;
#(
  parameter int AW = srh_pkg::ADDR_W,
  parameter int DW = srh_pkg::DATA_W
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_write,
  input  wire logic [AW-1:0]          req_addr,
  input  wire logic [DW-1:0]          req_wdata,
  output logic                        rsp_valid,
  output logic      [DW-1:0]          rsp_rdata,
  output logic      [AW-1:0]          word_select_lines,
  output logic                        select_low_active_n,
  output logic                        select_high_active,
  output logic                        out_enable_n,
  output logic                        write_strobe_n,
  output logic      [DW-1:0]          shared_data_pins_o,
  output logic                        shared_data_pins_oe_n,
  input  wire logic [DW-1:0]          shared_data_pins_i
);
  import srh_pkg::*;

  // the pin timing is worked out for one array shape only
  if (AW != ADDR_W || DW != DATA_W) begin : g_bad_shape
    $error("srh_ctrl: only 13 x 8 supported");
  end

  // every wait must fit the shared down counter
  if (WRITE_LOW_CYC >= (1 << CNT_W) || READ_WAIT_CYC >= (1 << CNT_W) ||
      FLOAT_CYC >= (1 << CNT_W) || SYNC_CYC >= (1 << CNT_W)) begin : g_bad_count
    $error("srh_ctrl: cycle count too large for the counter");
  end

  // address is set a cycle before the strobe falls, so that cycle counts too
  if ((WRITE_LOW_CYC + 1) * CLK_PERIOD_NS < ADDR_SETUP_NS) begin : g_bad_setup
    $error("srh_ctrl: clock too fast for the address setup");
  end

  //////////////////////////////////////////////////////////////////////////////
  srh_state_t       state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [AW-1:0]    addr_reg, addr_next;
  logic [DW-1:0]    wdata_reg, wdata_next;
  logic [DW-1:0]    rdata_reg, rdata_next;
  logic             rsp_reg, rsp_next;
  logic             sel_reg, sel_next;
  logic             oe_reg, oe_next;
  logic             we_reg, we_next;
  logic             drive_reg, drive_next;
  logic [DW-1:0]    pins_sync;

  // data pins are async to core_clk, so they pass two flops first
  srh_sync #(.WIDTH(DW)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (shared_data_pins_i),
    .sync_out (pins_sync)
  );

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n);
  endfunction

  // a wait ends when the counter is at one, or was loaded with zero
  function automatic logic cnt_last(input logic [CNT_W-1:0] c);
    return (c <= CNT_W'(1));
  endfunction

  function automatic logic [CNT_W-1:0] cnt_dec(input logic [CNT_W-1:0] c);
    return c - CNT_W'(1);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rsp_next   = 1'b0;
    sel_next   = sel_reg;
    oe_next    = oe_reg;
    we_next    = we_reg;
    drive_next = drive_reg;
    case (state_reg)
      SRH_IDLE: begin
        if (req_valid) begin
          addr_next  = req_addr;
          wdata_next = req_wdata;
          cnt_next   = cyc(1);
          if (req_write) begin
            oe_next    = 1'b0;                   // oe held high in write
            drive_next = 1'b1;
            state_next = SRH_W_SETUP;
          end else begin
            state_next = SRH_R_WAIT;
            sel_next   = 1'b1;                   // address set on the same edge
            oe_next    = 1'b1;
            cnt_next   = cyc(READ_WAIT_CYC);
          end
        end
      end
      SRH_W_SETUP: begin
        // address and data already stable one cycle before the strobe
        sel_next   = 1'b1;
        we_next    = 1'b1;
        cnt_next   = cyc(WRITE_LOW_CYC);
        state_next = SRH_W_LOW;
      end
      SRH_W_LOW: begin
        if (cnt_last(cnt_reg)) begin
          we_next    = 1'b0;                     // strobe rise ends the write
          state_next = SRH_W_END;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      SRH_W_END: begin
        // data and address held one cycle past the ending edge
        drive_next = 1'b0;
        sel_next   = 1'b0;
        cnt_next   = cyc(FLOAT_CYC);
        state_next = SRH_RECOVER;
      end
      SRH_R_WAIT: begin
        // access time is long past by the first edge after the selects
        if (cnt_last(cnt_reg)) begin
          state_next = SRH_R_DONE;
          cnt_next   = cyc(SYNC_CYC);            // two synchroniser stages
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      SRH_R_DONE: begin
        if (cnt_last(cnt_reg)) begin
          rdata_next = pins_sync;
          rsp_next   = 1'b1;
          sel_next   = 1'b0;
          oe_next    = 1'b0;
          cnt_next   = cyc(FLOAT_CYC);
          state_next = SRH_RECOVER;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      SRH_RECOVER: begin
        // wait for the device to float before the host may drive again
        if (cnt_last(cnt_reg)) begin
          state_next = SRH_IDLE;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      default: state_next = SRH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SRH_IDLE;
      cnt_reg   <= '0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rsp_reg   <= 1'b0;
      sel_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      we_reg    <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rsp_reg   <= rsp_next;
      sel_reg   <= sel_next;
      oe_reg    <= oe_next;
      we_reg    <= we_next;
      drive_reg <= drive_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign req_ready             = (state_reg == SRH_IDLE);
  assign rsp_valid             = rsp_reg;
  assign rsp_rdata             = rdata_reg;
  assign word_select_lines     = addr_reg;
  assign select_low_active_n   = ~sel_reg;   // both selects move together
  assign select_high_active    = sel_reg;
  assign out_enable_n          = ~oe_reg;
  assign write_strobe_n        = ~we_reg;    // low only in write states
  assign shared_data_pins_o    = wdata_reg;
  assign shared_data_pins_oe_n = ~drive_reg; // low while host drives
endmodule // srh_ctrl

/* File: tb/srh_sram_model.sv */
// sram partner model: 8k x 8 array behind the host pins
// assumes the bench resolves the shared data wire from the host enable alone
`timescale 1ns/1ps
module srh_sram_model (
  input  wire logic [12:0] addr,
  input  wire logic        sel_n,
  input  wire logic        sel,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  din,
  output logic      [7:0]  dout,
  output logic             drv
);
  logic [7:0] mem [8192];
  logic       wr;
  assign wr  = !sel_n && sel && !we_n;
  assign drv = !sel_n && sel && we_n && !oe_n;
  initial dout = 8'h5A;
  // first qualifier to drop ends the write
  always @(negedge wr) mem[addr] = din;
  // released pins show the inverse, so a stale byte never reads back by luck
  always @(addr, drv) if (drv) dout <= #3 mem[addr]; else dout <= ~dout;
endmodule // srh_sram_model

/* File: tb/srh_ctrl_asserts.sv */
// pin-level assertions for the sram host controller
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module srh_ctrl_asserts
  import srh_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic              rsp_valid,
  input wire logic [ADDR_W-1:0] word_select_lines,
  input wire logic              select_low_active_n,
  input wire logic              select_high_active,
  input wire logic              out_enable_n,
  input wire logic              write_strobe_n,
  input wire logic [DATA_W-1:0] shared_data_pins_o,
  input wire logic              shared_data_pins_oe_n
);
  logic on;
  assign on = !select_low_active_n && select_high_active;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  sequence wr_take; req_valid && req_ready && req_write; endsequence
  sequence rd_take; req_valid && req_ready && !req_write; endsequence
  sequence wr_walk;
    !on && !shared_data_pins_oe_n ##1 on && !write_strobe_n ##1 on && write_strobe_n
      ##1 !on && shared_data_pins_oe_n;
  endsequence
  a_write_walk: assert property (wr_take |=> wr_walk) else $error("write walk wrong");
  a_write_target: assert property (wr_take |=> word_select_lines == $past(req_addr)
    && shared_data_pins_o == $past(req_wdata)) else $error("write target wrong");
  a_strobe_qual: assert property (!write_strobe_n |-> on && !shared_data_pins_oe_n
    && out_enable_n) else $error("strobe unqualified");
  a_data_setup: assert property ($fell(write_strobe_n) |-> $stable(shared_data_pins_o)
    && $past(shared_data_pins_oe_n) == 1'b0) else $error("data setup short");
  a_data_hold: assert property ($rose(write_strobe_n) |-> $stable(shared_data_pins_o)
    && !shared_data_pins_oe_n) else $error("data hold short");
  a_addr_steady: assert property (on && $past(on) |-> $stable(word_select_lines))
    else $error("address moved while selected");
  a_read_strobe: assert property (!out_enable_n |-> write_strobe_n) else $error("strobe in read");
  a_read_walk: assert property (rd_take |=> on && !out_enable_n
    && word_select_lines == $past(req_addr) ##3 rsp_valid) else $error("read walk wrong");
endmodule // srh_ctrl_asserts
bind srh_ctrl srh_ctrl_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
  .req_wdata(req_wdata), .rsp_valid(rsp_valid), .word_select_lines(word_select_lines),
  .select_low_active_n(select_low_active_n), .select_high_active(select_high_active),
  .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n),
  .shared_data_pins_o(shared_data_pins_o), .shared_data_pins_oe_n(shared_data_pins_oe_n));

/* File: tb/srh_ctrl_tb.sv */
// bench: controller against the sram model, reads compared with a reference map
// assumes the model and checker files are compiled before this one
`timescale 1ns/1ps
module srh_ctrl_tb;
  import srh_pkg::*;
  logic              core_clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
  logic [ADDR_W-1:0] req_addr = '0, wsl;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, pin_o, pin_i, m_dout;
  logic              req_ready, rsp_valid, sel_n, sel, oe_n, we_n, pin_oe_n, m_drv;
  logic [7:0]        ref_mem [int];
  int                wq[$];
  int                error_cnt = 0, n_checks = 0, seed = 32'h12d8, a;
  always #50 core_clk = ~core_clk;
  assign pin_i = !pin_oe_n ? pin_o : m_dout;
  srh_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .word_select_lines(wsl),
    .select_low_active_n(sel_n), .select_high_active(sel), .out_enable_n(oe_n),
    .write_strobe_n(we_n), .shared_data_pins_o(pin_o), .shared_data_pins_oe_n(pin_oe_n),
    .shared_data_pins_i(pin_i));
  srh_sram_model u_mem (.addr(wsl), .sel_n(sel_n), .sel(sel), .oe_n(oe_n), .we_n(we_n),
    .din(pin_i), .dout(m_dout), .drv(m_drv));
  // host and array must never drive the shared pins together
  always @(negedge core_clk)
    if (rst_n) chk("pin_owner", 13'h0, 13'(!pin_oe_n && m_drv));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic op(input logic w, input logic [12:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, ad, d};
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    req_valid = 0;
    if (w) begin
      ref_mem[ad] = d;
      wq.push_back(ad);
    end else begin
      while (rsp_valid !== 1'b1 && n < 40) begin
        @(negedge core_clk);
        n++;
      end
      chk("rdata", ref_mem[ad], rsp_rdata);
    end
    chk("handshake", 1, n < 20);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // generous span: 43 operations of about five cycles each
  initial begin
    #(100 * 5000);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1;
    chk("idle_pins", 5'b10111, {sel_n, sel, oe_n, we_n, pin_oe_n});
    op(1, 13'h0000, 8'hA5);
    op(1, 13'h1FFF, 8'h5A);
    for (int i = 0; i < 12; i++) op(1, 13'($random(seed)), 8'($random(seed)));
    foreach (wq[i]) op(0, 13'(wq[i]), 8'h00);
    $display("test write_then_read done");
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      op(1, 13'(a), 8'($random(seed)));
      op(0, 13'(a), 8'h00);
    end
    $display("test back_to_back done");
    op(1, 13'h1234, 8'h3C);
    // reset lands while the strobe is low, so that byte is left undefined
    ref_mem.delete(13'h1234);
    @(negedge core_clk) rst_n = 0;
    #1 chk("abort_pins", 5'b10111, {sel_n, sel, oe_n, we_n, pin_oe_n});
    @(negedge core_clk) rst_n = 1;
    op(1, 13'h0ABC, 8'h96);
    op(0, 13'h0ABC, 8'h00);
    $display("test reset_abort done");
    end_sim();
  end
endmodule // srh_ctrl_tb
